// ===== src/vgc_pkg.sv
package vgc_pkg;
	localparam int COLS = 29;
	localparam int ROWS = 10;
	localparam int CELLS = 290;
	localparam int COEF_W = 16;
	localparam int X_W = 10;
	localparam int IDX_W = 9;
	localparam int FRAC_W = 8;
	localparam int SCALE_SHIFT = 4;
	localparam int ROUND_SHIFT = 2 * FRAC_W + SCALE_SHIFT;
	localparam int REC_MAX_PTS = 1024;
	localparam int ROW_BASE_PCT = 5;
	localparam int ROW_STEP_PCT = 10;
	localparam int PCT_FULL = 100;
	localparam logic [FRAC_W:0] W_ONE = 9'h100;
	localparam logic [1:0] REC_1024 = 2'h0;
	localparam logic [1:0] REC_512 = 2'h1;
	localparam logic [1:0] REC_256 = 2'h2;
	localparam logic [X_W-1:0] COL_POS [COLS] = '{
		10'h000, 10'h020, 10'h040, 10'h060, 10'h080, 10'h0a0, 10'h0c0, 10'h0e0,
		10'h100, 10'h140, 10'h180, 10'h1a0, 10'h1c0, 10'h1e0, 10'h200, 10'h220,
		10'h240, 10'h260, 10'h280, 10'h2c0, 10'h300, 10'h320, 10'h340, 10'h360,
		10'h380, 10'h3a0, 10'h3c0, 10'h3e0, 10'h3ff};
	localparam logic [IDX_W-1:0] IDX_FIRST = 9'h001;
	localparam logic [IDX_W-1:0] IDX_LAST = 9'h122;
	localparam logic [IDX_W-1:0] ADDR_LAST = 9'h121;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_LOCATE = 5'h02,
		ST_DIV = 5'h04,
		ST_CALC = 5'h08,
		ST_OUT = 5'h10
	} vgc_state_e;
endpackage

// ===== src/vgc_frac_div.sv
`timescale 1ns/1ps
// fraction num/den with num <= den, result in [0, 1] with FRAC_W fraction bits
module vgc_frac_div #(
	parameter int NUM_W = 10,
	parameter int FRAC_W = 8
) (
	input wire logic clk_sys_in, // system clock
	input wire logic reset_n_in, // sync reset, active low
	input wire logic start_in, // one-cycle start pulse
	input wire logic [NUM_W-1:0] num_in, // numerator
	input wire logic [NUM_W-1:0] den_in, // denominator, nonzero
	output logic [FRAC_W:0] quot_out, // quotient, msb is the integer bit
	output logic done_out // high from finish until next start
);
	logic [NUM_W:0] rem_reg;
	logic [NUM_W-1:0] den_reg;
	logic [4:0] cnt_reg;
	logic busy_reg;
	logic [NUM_W:0] rem_diff;
	logic rem_ge;

	// one restoring step per cycle; a small area over a 20 MHz budget
	assign rem_ge = rem_reg >= {1'b0, den_reg};
	assign rem_diff = rem_ge ? rem_reg - {1'b0, den_reg} : rem_reg;

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			rem_reg <= '0;
			den_reg <= '0;
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			done_out <= 1'b0;
			quot_out <= '0;
		end else if (start_in) begin
			rem_reg <= {1'b0, num_in};
			den_reg <= den_in;
			cnt_reg <= 5'(FRAC_W + 1);
			busy_reg <= 1'b1;
			done_out <= 1'b0;
			quot_out <= '0;
		end else if (busy_reg) begin
			quot_out <= {quot_out[FRAC_W-1:0], rem_ge};
			rem_reg <= {rem_diff[NUM_W-1:0], 1'b0};
			cnt_reg <= cnt_reg - 5'h01;
			if (cnt_reg == 5'h01) begin
				busy_reg <= 1'b0;
				done_out <= 1'b1;
			end
		end
	end
endmodule

// ===== src/vgc_defect.sv
`timescale 1ns/1ps
// defect list from the reference scan, removal from target data, list readout
module vgc_defect #(
	parameter int DEPTH = 16,
	parameter int LOC_W = 20,
	parameter int Z_W = 8
) (
	input wire logic clk_sys_in, // system clock
	input wire logic reset_n_in, // sync reset, active low
	input wire logic reference_scan_cmd_in, // pulse, new scan clears list
	input wire logic flag_valid_in, // pulse, defect found by scan
	input wire logic [LOC_W-1:0] flag_loc_in, // defect location
	input wire logic remove_en_in, // level, removal on
	input wire logic tgt_valid_in, // target sample valid
	input wire logic [LOC_W-1:0] tgt_loc_in, // target sample location
	input wire logic [Z_W-1:0] tgt_charge_in, // target sample charge
	output logic tgt_valid_out, // cleaned sample valid
	output logic [LOC_W-1:0] tgt_loc_out, // cleaned sample location
	output logic [Z_W-1:0] tgt_charge_out, // cleaned sample charge
	input wire logic defect_list_query_in, // pulse, start list readout
	output logic list_valid_out, // list word valid
	output logic [LOC_W-1:0] list_loc_out, // listed location
	output logic list_last_out, // final list word
	input wire logic list_ready_in, // list consumer ready
	output logic [5:0] list_count_out // stored defect count
);
	logic [LOC_W-1:0] loc_mem [DEPTH];
	logic [5:0] cnt_reg;
	logic [5:0] rd_idx_reg;
	logic [DEPTH-1:0] hit;

	assign list_count_out = cnt_reg;
	assign list_last_out = list_valid_out && (rd_idx_reg == cnt_reg - 6'h01);

	// a scan restarts the list; flags past the depth are dropped
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in || reference_scan_cmd_in) begin
			cnt_reg <= '0;
		end else if (flag_valid_in && cnt_reg < 6'(DEPTH)) begin
			loc_mem[cnt_reg[$clog2(DEPTH)-1:0]] <= flag_loc_in;
			cnt_reg <= cnt_reg + 6'h01;
		end
	end

	// one comparator per stored entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_hit
		assign hit[i] = (6'(i) < cnt_reg) && (loc_mem[i] == tgt_loc_in);
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			tgt_valid_out <= 1'b0;
			tgt_loc_out <= '0;
			tgt_charge_out <= '0;
		end else begin
			tgt_valid_out <= tgt_valid_in;
			tgt_loc_out <= tgt_loc_in;
			tgt_charge_out <= (remove_en_in && |hit) ? '0 : tgt_charge_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			list_valid_out <= 1'b0;
			rd_idx_reg <= '0;
			list_loc_out <= '0;
		end else if (!list_valid_out) begin
			if (defect_list_query_in && cnt_reg != '0) begin
				list_valid_out <= 1'b1;
				rd_idx_reg <= '0;
				list_loc_out <= loc_mem[0];
			end
		end else if (list_ready_in) begin
			if (list_last_out) begin
				list_valid_out <= 1'b0;
			end else begin
				rd_idx_reg <= rd_idx_reg + 6'h01;
				list_loc_out <= loc_mem[rd_idx_reg[$clog2(DEPTH)-1:0] + 1'b1];
			end
		end
	end
endmodule

// ===== src/vgc_vert_correct.sv
`timescale 1ns/1ps
// vertical geometry correction of centroided points, array store and readout
module vgc_vert_correct #(
	parameter int Y_W = 11,
	parameter int DEF_DEPTH = 16,
	parameter int LOC_W = 20,
	parameter int Z_W = 8
) (
	input wire logic clk_sys_in, // 20 MHz system clock
	input wire logic reset_n_in, // sync reset, active low
	input wire logic geom_enable_in, // level, correction on
	input wire logic [1:0] rec_len_in, // record length code
	input wire logic pt_valid_in, // centroided point valid
	output logic pt_ready_out, // point accepted when high
	input wire logic [vgc_pkg::X_W-1:0] pt_x_in, // point horizontal index
	input wire logic [Y_W-1:0] pt_y_in, // point vertical value
	output logic out_valid_out, // corrected point valid
	input wire logic out_ready_in, // consumer ready
	output logic [vgc_pkg::X_W-1:0] out_x_out, // horizontal index
	output logic [Y_W-1:0] out_y_out, // corrected vertical value
	input wire logic geom_set_in, // pulse, characterization start
	input wire logic char_done_in, // pulse, characterization finished
	output logic acq_running_out, // status: high running, low stopped
	input wire logic arr_wr_in, // pulse, write one constant
	input wire logic [vgc_pkg::IDX_W-1:0] arr_wr_idx_in, // index 1..290
	input wire logic signed [vgc_pkg::COEF_W-1:0] arr_wr_data_in, // constant
	input wire logic correction_array_query_in, // pulse, start readout
	output logic arr_rd_valid_out, // readout word valid
	output logic signed [vgc_pkg::COEF_W-1:0] arr_rd_data_out, // readout word
	output logic arr_rd_last_out, // final readout word
	input wire logic arr_rd_ready_in, // readout consumer ready
	input wire logic reference_scan_cmd_in, // pulse, new reference scan
	input wire logic defect_flag_valid_in, // pulse, scan found defect
	input wire logic [LOC_W-1:0] defect_flag_loc_in, // defect location
	input wire logic defect_remove_en_in, // level, removal on
	input wire logic tgt_valid_in, // raw target sample valid
	input wire logic [LOC_W-1:0] tgt_loc_in, // raw target location
	input wire logic [Z_W-1:0] tgt_charge_in, // raw target charge
	output logic tgt_valid_out, // cleaned target sample valid
	output logic [LOC_W-1:0] tgt_loc_out, // cleaned target location
	output logic [Z_W-1:0] tgt_charge_out, // cleaned target charge
	input wire logic defect_list_query_in, // pulse, start defect list
	output logic list_valid_out, // defect list word valid
	output logic [LOC_W-1:0] list_loc_out, // listed defect location
	output logic list_last_out, // final defect list word
	input wire logic list_ready_in, // defect list consumer ready
	output logic [5:0] list_count_out // stored defect count
);
	localparam int XW = vgc_pkg::X_W;
	localparam int FW = vgc_pkg::FRAC_W;
	localparam int CW = vgc_pkg::COEF_W;
	localparam int AW = vgc_pkg::IDX_W;
	localparam int PW = 2 * (FW + 1) + CW + 3;

	vgc_pkg::vgc_state_e state_reg;
	logic signed [CW-1:0] coef_mem [vgc_pkg::CELLS];
	logic [XW-1:0] col_pos [vgc_pkg::COLS];
	logic [vgc_pkg::COLS-1:0] col_ge;
	logic [Y_W-1:0] row_pos [vgc_pkg::ROWS];
	logic [vgc_pkg::ROWS-1:0] row_ge;
	logic [1:0] rec_shift;
	logic [XW-1:0] rec_last, den_t, num_t, dx, num_t_reg, den_t_reg;
	logic [4:0] col_cnt, col_sel, col_reg;
	logic [3:0] row_cnt, row_sel, row_reg;
	logic lo_mode, hi_mode, zero_lo_reg, zero_hi_reg, div_start, t_done, u_done, accept;
	logic [Y_W-1:0] den_u, num_u, num_u_reg, den_u_reg, y_reg;
	logic [FW:0] t_q, u_q;
	logic [AW-1:0] addr_ll, rd_idx_reg;
	logic signed [CW-1:0] corner_low_left, corner_low_right;
	logic signed [CW-1:0] corner_high_left, corner_high_right;
	logic [2*FW+1:0] w_ll, w_lr, w_hr, w_hl;
	logic signed [PW-1:0] c_acc, c_round, y_sum;

	assign accept = pt_valid_in && pt_ready_out;
	assign pt_ready_out = state_reg == vgc_pkg::ST_IDLE;
	assign out_valid_out = state_reg == vgc_pkg::ST_OUT;
	assign div_start = state_reg == vgc_pkg::ST_LOCATE;

	always_comb begin
		unique case (rec_len_in)
			vgc_pkg::REC_512: rec_shift = 2'h1;
			vgc_pkg::REC_256: rec_shift = 2'h2;
			default: rec_shift = 2'h0;
		endcase
	end
	assign rec_last = XW'((vgc_pkg::REC_MAX_PTS >> rec_shift) - 1);

	// column grid for the current record length
	for (genvar k = 0; k < vgc_pkg::COLS; k++) begin : g_col
		if (k == vgc_pkg::COLS - 1) begin : g_last
			assign col_pos[k] = rec_last;
		end else begin : g_tab
			assign col_pos[k] = vgc_pkg::COL_POS[k] >> rec_shift;
		end
		assign col_ge[k] = pt_x_in >= col_pos[k];
	end

	// rows bottom to top, 5% to 95% in 10% steps
	for (genvar r = 0; r < vgc_pkg::ROWS; r++) begin : g_row
		assign row_pos[r] = Y_W'(((2 ** Y_W) * (vgc_pkg::ROW_BASE_PCT
			+ vgc_pkg::ROW_STEP_PCT * r)) / vgc_pkg::PCT_FULL);
		assign row_ge[r] = pt_y_in >= row_pos[r];
	end

	always_comb begin
		col_cnt = '0;
		row_cnt = '0;
		for (int k = 0; k < vgc_pkg::COLS; k++) begin
			col_cnt = col_cnt + 5'(col_ge[k]);
		end
		for (int r = 0; r < vgc_pkg::ROWS; r++) begin
			row_cnt = row_cnt + 4'(row_ge[r]);
		end
	end

	assign lo_mode = row_cnt == 4'h0;
	assign hi_mode = pt_y_in > row_pos[vgc_pkg::ROWS-1];

	always_comb begin
		col_sel = (col_cnt >= 5'(vgc_pkg::COLS)) ? 5'(vgc_pkg::COLS - 2) : col_cnt - 5'h01;
		if (lo_mode) begin
			row_sel = 4'h0;
		end else if (row_cnt >= 4'(vgc_pkg::ROWS)) begin
			row_sel = 4'(vgc_pkg::ROWS - 2);
		end else begin
			row_sel = row_cnt - 4'h01;
		end
	end

	always_comb begin
		den_t = col_pos[col_sel + 5'h01] - col_pos[col_sel];
		dx = pt_x_in - col_pos[col_sel];
		// points past the record end are clamped onto the last column
		num_t = (dx > den_t) ? den_t : dx;
		den_u = row_pos[row_sel + 4'h1] - row_pos[row_sel];
		if (lo_mode) begin
			num_u = '0;
		end else if (hi_mode) begin
			num_u = den_u;
		end else begin
			num_u = pt_y_in - row_pos[row_sel];
		end
	end

	// point capture and cell registers
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			col_reg <= '0;
			row_reg <= '0;
			zero_lo_reg <= 1'b0;
			zero_hi_reg <= 1'b0;
			num_t_reg <= '0;
			den_t_reg <= '0;
			num_u_reg <= '0;
			den_u_reg <= '0;
			y_reg <= '0;
			out_x_out <= '0;
		end else if (accept) begin
			col_reg <= col_sel;
			row_reg <= row_sel;
			zero_lo_reg <= hi_mode;
			zero_hi_reg <= lo_mode;
			num_t_reg <= num_t;
			den_t_reg <= den_t;
			num_u_reg <= num_u;
			den_u_reg <= den_u;
			y_reg <= pt_y_in;
			out_x_out <= pt_x_in;
		end
	end

	vgc_frac_div #(.NUM_W(XW), .FRAC_W(FW)) u_div_t (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.start_in(div_start),
		.num_in(num_t_reg),
		.den_in(den_t_reg),
		.quot_out(t_q),
		.done_out(t_done)
	);

	vgc_frac_div #(.NUM_W(Y_W), .FRAC_W(FW)) u_div_u (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.start_in(div_start),
		.num_in(num_u_reg),
		.den_in(den_u_reg),
		.quot_out(u_q),
		.done_out(u_done)
	);

	always_comb begin
		addr_ll = AW'(row_reg * vgc_pkg::COLS + col_reg);
		corner_low_left = zero_lo_reg ? '0 : coef_mem[addr_ll];
		corner_low_right = zero_lo_reg ? '0 : coef_mem[addr_ll + 9'h001];
		corner_high_left = zero_hi_reg ? '0 : coef_mem[addr_ll + 9'(vgc_pkg::COLS)];
		corner_high_right = zero_hi_reg ? '0 : coef_mem[addr_ll + 9'(vgc_pkg::COLS + 1)];
	end

	always_comb begin
		// weights formed at full width; a product inside a concatenation keeps only nine bits
		w_ll = (vgc_pkg::W_ONE - t_q) * (vgc_pkg::W_ONE - u_q);
		w_lr = t_q * (vgc_pkg::W_ONE - u_q);
		w_hr = t_q * u_q;
		w_hl = (vgc_pkg::W_ONE - t_q) * u_q;
		c_acc = PW'($signed({1'b0, w_ll})) * PW'(corner_low_left)
			+ PW'($signed({1'b0, w_lr})) * PW'(corner_low_right)
			+ PW'($signed({1'b0, w_hr})) * PW'(corner_high_right)
			+ PW'($signed({1'b0, w_hl})) * PW'(corner_high_left);
		c_round = (c_acc + (PW'(1) <<< (vgc_pkg::ROUND_SHIFT - 1))) >>> vgc_pkg::ROUND_SHIFT;
		y_sum = PW'($signed({1'b0, y_reg})) + c_round;
	end

	// target samples take a separate path
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state_reg <= vgc_pkg::ST_IDLE;
			out_y_out <= '0;
		end else begin
			unique case (state_reg)
				vgc_pkg::ST_IDLE: begin
					if (accept) begin
						if (geom_enable_in) begin
							state_reg <= vgc_pkg::ST_LOCATE;
						end else begin
							out_y_out <= pt_y_in;
							state_reg <= vgc_pkg::ST_OUT;
						end
					end
				end
				vgc_pkg::ST_LOCATE: state_reg <= vgc_pkg::ST_DIV;
				vgc_pkg::ST_DIV: begin
					if (t_done && u_done) begin
						state_reg <= vgc_pkg::ST_CALC;
					end
				end
				vgc_pkg::ST_CALC: begin
					if (y_sum < 0) begin
						out_y_out <= '0;
					end else if (y_sum > PW'((2 ** Y_W) - 1)) begin
						out_y_out <= '1;
					end else begin
						out_y_out <= y_sum[Y_W-1:0];
					end
					state_reg <= vgc_pkg::ST_OUT;
				end
				vgc_pkg::ST_OUT: begin
					if (out_ready_in) begin
						state_reg <= vgc_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// array store; cleared so an uncharacterized grid corrects by zero
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < vgc_pkg::CELLS; i++) begin
				coef_mem[i] <= '0;
			end
		end else if (arr_wr_in && arr_wr_idx_in >= vgc_pkg::IDX_FIRST
			&& arr_wr_idx_in <= vgc_pkg::IDX_LAST) begin
			coef_mem[arr_wr_idx_in - vgc_pkg::IDX_FIRST] <= arr_wr_data_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			acq_running_out <= 1'b0;
		end else if (geom_set_in) begin
			acq_running_out <= 1'b1;
		end else if (char_done_in) begin
			acq_running_out <= 1'b0;
		end
	end

	assign arr_rd_last_out = arr_rd_valid_out && (rd_idx_reg == vgc_pkg::ADDR_LAST);
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			arr_rd_valid_out <= 1'b0;
			rd_idx_reg <= '0;
			arr_rd_data_out <= '0;
		end else if (!arr_rd_valid_out) begin
			if (correction_array_query_in) begin
				arr_rd_valid_out <= 1'b1;
				rd_idx_reg <= '0;
				arr_rd_data_out <= coef_mem[0];
			end
		end else if (arr_rd_ready_in) begin
			if (arr_rd_last_out) begin
				arr_rd_valid_out <= 1'b0;
			end else begin
				rd_idx_reg <= rd_idx_reg + 9'h001;
				arr_rd_data_out <= coef_mem[rd_idx_reg + 9'h001];
			end
		end
	end

	vgc_defect #(
		.DEPTH(DEF_DEPTH),
		.LOC_W(LOC_W),
		.Z_W(Z_W)
	) u_defect (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.reference_scan_cmd_in(reference_scan_cmd_in),
		.flag_valid_in(defect_flag_valid_in),
		.flag_loc_in(defect_flag_loc_in),
		.remove_en_in(defect_remove_en_in),
		.tgt_valid_in(tgt_valid_in),
		.tgt_loc_in(tgt_loc_in),
		.tgt_charge_in(tgt_charge_in),
		.tgt_valid_out(tgt_valid_out),
		.tgt_loc_out(tgt_loc_out),
		.tgt_charge_out(tgt_charge_out),
		.defect_list_query_in(defect_list_query_in),
		.list_valid_out(list_valid_out),
		.list_loc_out(list_loc_out),
		.list_last_out(list_last_out),
		.list_ready_in(list_ready_in),
		.list_count_out(list_count_out)
	);
endmodule

// ===== dv/vgc_vert_correct_chk.sv
`timescale 1ns/1ps
// port-level checks of the point path, status and array readout
module vgc_vert_correct_chk #(
	parameter int Y_W = 11
) (
	input wire logic clk_sys_in, // clock
	input wire logic reset_n_in, // reset
	input wire logic geom_enable_in, // on
	input wire logic pt_valid_in, // pt valid
	input wire logic pt_ready_out, // pt ready
	input wire logic [vgc_pkg::X_W-1:0] pt_x_in, // x
	input wire logic [Y_W-1:0] pt_y_in, // y
	input wire logic out_valid_out, // out valid
	input wire logic out_ready_in, // out ready
	input wire logic [vgc_pkg::X_W-1:0] out_x_out, // x
	input wire logic [Y_W-1:0] out_y_out, // y
	input wire logic geom_set_in, // set
	input wire logic char_done_in, // done
	input wire logic acq_running_out, // status
	input wire logic correction_array_query_in, // query
	input wire logic arr_rd_valid_out, // rd valid
	input wire logic signed [vgc_pkg::COEF_W-1:0] arr_rd_data_out, // rd data
	input wire logic arr_rd_last_out, // rd last
	input wire logic arr_rd_ready_in // rd ready
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	logic [vgc_pkg::X_W-1:0] x_reg;
	// x of the point in flight, to tie the output back to its cause
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			x_reg <= '0;
		end else if (pt_valid_in && pt_ready_out) begin
			x_reg <= pt_x_in;
		end
	end
	a_pass_disabled: assert property (pt_valid_in && pt_ready_out && !geom_enable_in
		|=> out_valid_out && out_y_out == $past(pt_y_in)) else $error("bypass value wrong");
	a_enabled_lat: assert property (pt_valid_in && pt_ready_out && geom_enable_in
		|-> ##1 (!out_valid_out)[*8] ##5 out_valid_out) else $error("latency wrong");
	a_x_kept: assert property (out_valid_out |-> out_x_out == x_reg)
		else $error("x changed");
	a_out_hold: assert property (out_valid_out && !out_ready_in
		|=> out_valid_out && $stable(out_y_out)) else $error("output not held");
	a_busy_refuse: assert property (out_valid_out |-> !pt_ready_out)
		else $error("ready while busy");
	a_status_set: assert property (geom_set_in |=> acq_running_out)
		else $error("status not running");
	a_status_clear: assert property (char_done_in && !geom_set_in |=> !acq_running_out)
		else $error("status not stopped");
	a_rd_answer: assert property (correction_array_query_in && !arr_rd_valid_out
		|=> arr_rd_valid_out) else $error("readout not started");
	a_rd_hold: assert property (arr_rd_valid_out && !arr_rd_ready_in
		|=> arr_rd_valid_out && $stable(arr_rd_data_out)) else $error("word not held");
	a_last_flag: assert property (arr_rd_last_out && arr_rd_ready_in |=> !arr_rd_valid_out)
		else $error("readout not ended");
endmodule

bind vgc_vert_correct vgc_vert_correct_chk #(.Y_W(Y_W)) vgc_vert_correct_chk_i (.clk_sys_in,
	.reset_n_in, .geom_enable_in, .pt_valid_in, .pt_ready_out, .pt_x_in, .pt_y_in,
	.out_valid_out, .out_ready_in, .out_x_out, .out_y_out, .geom_set_in, .char_done_in,
	.acq_running_out, .correction_array_query_in, .arr_rd_valid_out, .arr_rd_data_out,
	.arr_rd_last_out, .arr_rd_ready_in);

// ===== dv/vgc_pt_partner.sv
`timescale 1ns/1ps
// centroid stage feeding points and consumer taking corrected points
module vgc_pt_partner (
	input wire logic clk_sys_in, // clock
	input wire logic send_in, // pulse, offer a point
	input wire logic [9:0] x_in, // x to offer
	input wire logic [10:0] y_in, // y to offer
	input wire logic [3:0] stall_in, // cycles before ready
	input wire logic pt_ready_in, // design ready
	input wire logic out_valid_in, // design result valid
	input wire logic [9:0] out_x_in, // result x
	input wire logic [10:0] out_y_in, // result y
	output logic pt_valid_out = 1'b0, // point valid
	output logic [9:0] pt_x_out = 10'h000, // point x
	output logic [10:0] pt_y_out = 11'h000, // point y
	output logic out_ready_out = 1'b0, // consumer ready
	output logic got_out = 1'b0, // pulse, result taken
	output logic [9:0] got_x_out = 10'h000, // taken x
	output logic [10:0] got_y_out = 11'h000 // taken y
);
	int wait_cnt = 0;
	// sample at the edge, change just after it
	always @(posedge clk_sys_in) begin
		logic acc;
		logic take;
		logic snd;
		acc = pt_valid_out && pt_ready_in;
		take = out_valid_in && out_ready_out;
		snd = send_in;
		got_out <= take;
		if (take) begin
			got_x_out <= out_x_in;
			got_y_out <= out_y_in;
		end
		#1;
		if (acc) begin
			pt_valid_out = 1'b0;
			pt_x_out = ~pt_x_out; // released lines no longer show the point
			pt_y_out = ~pt_y_out;
		end
		if (snd) begin
			pt_valid_out = 1'b1;
			pt_x_out = x_in;
			pt_y_out = y_in;
		end
		// slow consumer stalls a set number of cycles
		if (take) begin
			out_ready_out = 1'b0;
			wait_cnt = 0;
		end else if (out_valid_in) begin
			if (wait_cnt >= stall_in) out_ready_out = 1'b1;
			else wait_cnt++;
		end
	end
endmodule

// ===== dv/vgc_vert_correct_tb_top.sv
`timescale 1ns/1ps
module vgc_vert_correct_tb_top;
	logic clk_sys_in = 1'b0, reset_n_in = 1'b0, geom_enable_in = 1'b0;
	logic [1:0] rec_len_in = 2'h0;
	logic geom_set_in = 1'b0, char_done_in = 1'b0, arr_wr_in = 1'b0, arr_rd_ready_in = 1'b0;
	logic [8:0] arr_wr_idx_in = 9'h000;
	logic signed [15:0] arr_wr_data_in = 16'h0000;
	logic correction_array_query_in = 1'b0, reference_scan_cmd_in = 1'b0;
	logic defect_flag_valid_in = 1'b0, defect_remove_en_in = 1'b0, tgt_valid_in = 1'b0;
	logic [19:0] defect_flag_loc_in = 20'h00000, tgt_loc_in = 20'h00000;
	logic [7:0] tgt_charge_in = 8'h00;
	logic defect_list_query_in = 1'b0, list_ready_in = 1'b0, send = 1'b0;
	logic [9:0] sx = 10'h000;
	logic [10:0] sy = 11'h000;
	logic [3:0] stall = 4'h0;
	wire logic pt_valid_in, pt_ready_out, out_valid_out, out_ready_in, acq_running_out, got;
	wire logic [9:0] pt_x_in, out_x_out, gx;
	wire logic [10:0] pt_y_in, out_y_out, gy;
	wire logic arr_rd_valid_out, arr_rd_last_out, tgt_valid_out, list_valid_out, list_last_out;
	wire logic signed [15:0] arr_rd_data_out;
	wire logic [19:0] tgt_loc_out, list_loc_out;
	wire logic [7:0] tgt_charge_out;
	wire logic [5:0] list_count_out;
	int error_cnt = 0, cmp_count = 0;
	vgc_vert_correct vgc_vert_correct_i (.clk_sys_in, .reset_n_in, .geom_enable_in,
		.rec_len_in, .pt_valid_in, .pt_ready_out, .pt_x_in, .pt_y_in, .out_valid_out,
		.out_ready_in, .out_x_out, .out_y_out, .geom_set_in, .char_done_in,
		.acq_running_out, .arr_wr_in, .arr_wr_idx_in, .arr_wr_data_in,
		.correction_array_query_in, .arr_rd_valid_out, .arr_rd_data_out, .arr_rd_last_out,
		.arr_rd_ready_in, .reference_scan_cmd_in, .defect_flag_valid_in, .defect_flag_loc_in,
		.defect_remove_en_in, .tgt_valid_in, .tgt_loc_in, .tgt_charge_in, .tgt_valid_out,
		.tgt_loc_out, .tgt_charge_out, .defect_list_query_in, .list_valid_out,
		.list_loc_out, .list_last_out, .list_ready_in, .list_count_out);
	vgc_pt_partner vgc_pt_partner_i (.clk_sys_in, .send_in(send), .x_in(sx), .y_in(sy),
		.stall_in(stall), .pt_ready_in(pt_ready_out), .out_valid_in(out_valid_out),
		.out_x_in(out_x_out), .out_y_in(out_y_out), .pt_valid_out(pt_valid_in),
		.pt_x_out(pt_x_in), .pt_y_out(pt_y_in), .out_ready_out(out_ready_in),
		.got_out(got), .got_x_out(gx), .got_y_out(gy));
	// 20 MHz clock
	always #25 clk_sys_in = ~clk_sys_in;
	task automatic tick;
		@(posedge clk_sys_in);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// stored pattern: correction col+0.5 inside, col-4 bottom row, col+3 top row
	function automatic logic signed [15:0] coef(input int i);
		int r;
		int c;
		r = (i - 1) / vgc_pkg::COLS;
		c = (i - 1) % vgc_pkg::COLS;
		if (r == 0) return 16'(16 * c - 64);
		if (r == 9) return 16'(16 * c + 48);
		return 16'(16 * c + 8);
	endfunction
	task automatic pt(input logic [9:0] x, input logic [10:0] y, input logic [10:0] e);
		int n;
		sx = x;
		sy = y;
		send = 1'b1;
		tick;
		send = 1'b0;
		n = 0;
		while (got !== 1'b1 && n < 60) begin
			tick;
			n++;
		end
		chk("out_y", {21'h0, e}, {21'h0, gy});
		chk("out_x", {22'h0, x}, {22'h0, gx});
	endtask
	task automatic t_status;
		geom_set_in = 1'b1;
		tick;
		geom_set_in = 1'b0;
		chk("acq_running", 1, {31'h0, acq_running_out});
		char_done_in = 1'b1;
		tick;
		char_done_in = 1'b0;
		chk("acq_stopped", 0, {31'h0, acq_running_out});
	endtask
	task automatic wr_array;
		for (int i = 1; i <= vgc_pkg::CELLS; i++) begin
			arr_wr_in = 1'b1;
			arr_wr_idx_in = 9'(i);
			arr_wr_data_in = coef(i);
			tick;
		end
		arr_wr_in = 1'b0;
	endtask
	task automatic t_readout;
		int n;
		correction_array_query_in = 1'b1;
		tick;
		correction_array_query_in = 1'b0;
		for (int i = 1; i <= vgc_pkg::CELLS; i++) begin
			n = 0;
			while (arr_rd_valid_out !== 1'b1 && n < 10) begin
				tick;
				n++;
			end
			chk("arr_data", {16'h0, coef(i)}, {16'h0, arr_rd_data_out});
			chk("arr_last", {31'h0, i == vgc_pkg::CELLS}, {31'h0, arr_rd_last_out});
			arr_rd_ready_in = 1'b1;
			tick;
			// ready stays up between words, with a one-cycle pause every third word
			if (i % 3 == 0) begin
				arr_rd_ready_in = 1'b0;
				tick;
			end
		end
		arr_rd_ready_in = 1'b0;
		chk("arr_end", 0, {31'h0, arr_rd_valid_out});
	endtask
	task automatic t_cols;
		for (int l = 0; l < 3; l++) begin
			rec_len_in = 2'(l);
			for (int k = 0; k < vgc_pkg::COLS; k++) begin
				pt(vgc_pkg::COL_POS[k] >> l, 11'h3e8, 11'(1001 + k));
			end
		end
	endtask
	task automatic t_clamp;
		logic [9:0] xs [5] = '{10'h000, 10'h000, 10'h000, 10'h3ff, 10'h020};
		logic [10:0] ys [5] = '{11'h7d0, 11'h032, 11'h001, 11'h7ff, 11'h7d0};
		logic [10:0] es [5] = '{11'h7d3, 11'h02e, 11'h000, 11'h7ff, 11'h7d4};
		rec_len_in = 2'h3; // spare code runs as 1024 points
		stall = 4'h3;
		for (int i = 0; i < 5; i++) pt(xs[i], ys[i], es[i]);
		stall = 4'h0;
		geom_enable_in = 1'b0;
		pt(10'h005, 11'h3e8, 11'h3e8);
		pt(10'h3ff, 11'h7ff, 11'h7ff);
	endtask
	task automatic tgt(input logic [19:0] loc, input logic [7:0] e);
		tgt_valid_in = 1'b1;
		tgt_loc_in = loc;
		tgt_charge_in = 8'h5a;
		tick;
		tgt_valid_in = 1'b0;
		tgt_loc_in = ~loc;
		chk("tgt_valid", 1, {31'h0, tgt_valid_out});
		chk("tgt_loc", {12'h0, loc}, {12'h0, tgt_loc_out});
		chk("tgt_charge", {24'h0, e}, {24'h0, tgt_charge_out});
		tick;
		chk("tgt_idle", 0, {31'h0, tgt_valid_out});
	endtask
	task automatic t_defect;
		logic [19:0] locs [2] = '{20'h12345, 20'h0abcd};
		reference_scan_cmd_in = 1'b1;
		tick;
		reference_scan_cmd_in = 1'b0;
		defect_flag_valid_in = 1'b1;
		defect_flag_loc_in = locs[0];
		tick;
		defect_flag_loc_in = locs[1];
		tick;
		defect_flag_valid_in = 1'b0;
		tick;
		chk("list_count", 2, {26'h0, list_count_out});
		defect_remove_en_in = 1'b1;
		tgt(locs[0], 8'h00);
		tgt(20'h00777, 8'h5a);
		defect_remove_en_in = 1'b0;
		tgt(locs[0], 8'h5a);
		defect_list_query_in = 1'b1;
		tick;
		defect_list_query_in = 1'b0;
		for (int i = 0; i < 2; i++) begin
			if (list_valid_out !== 1'b1) tick;
			chk("list_loc", {12'h0, locs[i]}, {12'h0, list_loc_out});
			chk("list_last", {31'h0, i == 1}, {31'h0, list_last_out});
			list_ready_in = 1'b1;
			tick;
		end
		list_ready_in = 1'b0;
		chk("list_end", 0, {31'h0, list_valid_out});
	endtask
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// main sequence after a four-cycle reset
	initial begin
		repeat (4) @(posedge clk_sys_in);
		#1;
		reset_n_in = 1'b1;
		t_status;
		wr_array;
		t_readout;
		geom_enable_in = 1'b1;
		t_cols;
		t_clamp;
		t_defect;
		stop_test;
	end
	// watchdog, well beyond the expected few thousand cycles
	initial begin
		#(50 * 30000);
		error_cnt++;
		stop_test;
	end
endmodule
